// file: rtl/axis_monitor_pkg.sv
/*
  Constants for the axis supervision block: register offsets, field positions,
  reset values and operating states.
  Assumes a 32-bit AXI4-Lite register bus and a 40 MHz clock.
*/
package axis_monitor_pkg;

  // register byte offsets
  localparam logic [7:0] ADDR_AXIS_INPUT_ENABLE = 8'h00;
  localparam logic [7:0] ADDR_AXIS_INPUT_POLARITY = 8'h04;
  localparam logic [7:0] ADDR_AXIS_EVENT_LATCH = 8'h08;
  localparam logic [7:0] ADDR_DRIVE_COMMAND_WORD = 8'h0C;
  localparam logic [7:0] ADDR_WARNING_WORD = 8'h10;
  localparam logic [7:0] ADDR_ACTUAL_MODE_STATUS = 8'h14;
  localparam logic [7:0] ADDR_OVERRUN_REPORT_SELECT = 8'h18;
  localparam logic [7:0] ADDR_DRIVE_STATUS_WORD = 8'h1C;
  localparam logic [7:0] ADDR_POSITION = 8'h20;
  localparam logic [7:0] ADDR_MOTION_REQUEST = 8'h24;

  // axis input bit positions
  localparam int BIT_POS_LIMIT = 0;
  localparam int BIT_NEG_LIMIT = 1;
  localparam int BIT_STOP = 2;
  localparam int BIT_REF = 3;
  localparam int AXIS_INPUTS = 4;

  // drive command word bits
  localparam int BIT_CMD_SW_STOP = 2;
  localparam int BIT_CMD_FAULT_RESET = 3;
  localparam int BIT_CMD_QS_RELEASE = 4;

  // status bits
  localparam int BIT_WARN_OVERRUN = 0;
  localparam int BIT_MODE_REF_OK = 5;
  localparam int BIT_STAT_WARNING = 7;
  localparam int BIT_STAT_QUICK_STOP = 0;
  localparam int BIT_STAT_OP_ENABLED = 1;
  localparam int BIT_STAT_AMP_ON = 2;
  localparam int BIT_STAT_ABS_REFUSED = 3;

  // motion request register fields
  localparam int BIT_REQ_MODE_LSB = 0;
  localparam int BIT_REQ_GO = 4;

  // reset values and increments per revolution
  localparam logic [3:0] RESET_INPUT_ENABLE = 4'h0;
  localparam logic [3:0] RESET_INPUT_POLARITY = 4'h0;
  localparam logic RESET_OVERRUN_REPORT = 1'b0;
  localparam int INCREMENTS_PER_REV = 12;

  typedef enum logic [2:0] {
    MODE_IDLE,
    MODE_JOG,
    MODE_HOMING,
    MODE_DIMENSION_SET,
    MODE_PROFILE_VELOCITY,
    MODE_POSITION_ABS,
    MODE_POSITION_REL
  } motion_mode_e;

  typedef enum {
    ST_OPERATION_ENABLED,
    ST_QUICK_STOP,
    ST_FAULT
  } drive_state_e;

endpackage

// file: rtl/axis_monitor.sv
/*
  Axis supervision: limit, stop and reference switch inputs with enable and
  polarity, latched events, quick stop, software stop, and position range
  overrun handling, all reached over an AXI4-Lite slave.
  Assumes switch pins are asynchronous and the position pulses come from the
  motor commutation logic on aclk.
*/
`timescale 1ns/1ps

module axis_monitor #(
  parameter int SYNC_STAGES = 2,
  parameter int POS_WIDTH = 32
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // switch pins
  input wire logic pos_limit_switch,
  input wire logic neg_limit_switch,
  input wire logic stop_switch,
  input wire logic ref_switch,
  // motion feedback, one pulse per increment, same clock
  input wire logic pos_step_up,
  input wire logic pos_step_down,
  // drive control outputs
  output logic quick_stop,
  output logic amp_enable,
  output logic motion_active
);

  // ------------------------------------------------------------
  // input synchronisers
  // ------------------------------------------------------------
  logic [3:0] pins_meta;
  logic [3:0] pins_sync;
  wire [3:0] pins_raw = {ref_switch, stop_switch, neg_limit_switch, pos_limit_switch};

  // first flop only feeds the second; metastability settles there
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pins_meta <= 4'h0;
      pins_sync <= 4'h0;
    end else if (clk_en) begin
      pins_meta <= pins_raw;
      pins_sync <= pins_meta;
    end
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  logic [3:0] axis_input_enable;
  logic [3:0] axis_input_polarity;
  logic [3:0] axis_event_latch;
  logic overrun_report_select;
  logic overrun_warning;
  logic ref_ok;
  logic signed [POS_WIDTH-1:0] position;
  axis_monitor_pkg::motion_mode_e mode;
  axis_monitor_pkg::drive_state_e state;

  // active level per polarity, masked by enable
  wire [3:0] input_active = ~(pins_sync ^ axis_input_polarity) & axis_input_enable;

  wire homing = (mode == axis_monitor_pkg::MODE_HOMING);
  wire jog = (mode == axis_monitor_pkg::MODE_JOG);
  wire dim_set = (mode == axis_monitor_pkg::MODE_DIMENSION_SET);
  wire wrap_ok = jog
    || (mode == axis_monitor_pkg::MODE_PROFILE_VELOCITY)
    || (mode == axis_monitor_pkg::MODE_POSITION_REL);

  // limits stop normal moves; homing and jog may retract at any time
  wire limit_hit = (input_active[axis_monitor_pkg::BIT_POS_LIMIT]
    || input_active[axis_monitor_pkg::BIT_NEG_LIMIT]) && !(homing || jog);
  // reference switch stops only when enabled and not homing
  wire ref_stop = input_active[axis_monitor_pkg::BIT_REF] && !homing;
  wire stop_hit = input_active[axis_monitor_pkg::BIT_STOP] || ref_stop;

  // ------------------------------------------------------------
  // AXI4-Lite write path
  // ------------------------------------------------------------
  logic aw_held;
  logic w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;

  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  wire aw_take = s_axi_awvalid && s_axi_awready;
  wire w_take = s_axi_wvalid && s_axi_wready;
  wire aw_now = aw_held || aw_take;
  wire w_now = w_held || w_take;
  wire [7:0] wr_addr = aw_held ? aw_addr : s_axi_awaddr;
  wire [31:0] wr_data = w_held ? w_data : s_axi_wdata;
  wire [3:0] wr_strb = w_held ? w_strb : s_axi_wstrb;
  // clk_en low holds every handshake register, so no write completes then
  wire wr_fire = aw_now && w_now && !s_axi_bvalid && clk_en;
  wire wr_lane0 = wr_fire && wr_strb[0];

  wire wr_map = (wr_addr <= axis_monitor_pkg::ADDR_MOTION_REQUEST) && (wr_addr[1:0] == 2'b00);
  wire wr_enable = wr_lane0 && (wr_addr == axis_monitor_pkg::ADDR_AXIS_INPUT_ENABLE);
  wire wr_polarity = wr_lane0 && (wr_addr == axis_monitor_pkg::ADDR_AXIS_INPUT_POLARITY);
  wire wr_command = wr_lane0 && (wr_addr == axis_monitor_pkg::ADDR_DRIVE_COMMAND_WORD);
  wire wr_report = wr_lane0 && (wr_addr == axis_monitor_pkg::ADDR_OVERRUN_REPORT_SELECT);
  wire wr_request = wr_lane0 && (wr_addr == axis_monitor_pkg::ADDR_MOTION_REQUEST);

  wire cmd_sw_stop = wr_command && wr_data[axis_monitor_pkg::BIT_CMD_SW_STOP];
  wire cmd_fault_reset = wr_command && wr_data[axis_monitor_pkg::BIT_CMD_FAULT_RESET];
  wire cmd_qs_release = wr_command && wr_data[axis_monitor_pkg::BIT_CMD_QS_RELEASE];
  wire [2:0] req_mode = wr_data[axis_monitor_pkg::BIT_REQ_MODE_LSB +: 3];
  wire req_go = wr_request && wr_data[axis_monitor_pkg::BIT_REQ_GO];
  // absolute moves refused after overrun; a travel command needs the drive enabled
  wire req_abs = (req_mode == 3'(axis_monitor_pkg::MODE_POSITION_ABS));
  wire req_ok = req_go && (state == axis_monitor_pkg::ST_OPERATION_ENABLED)
    && !(req_abs && overrun_warning) && (req_mode <= 3'(axis_monitor_pkg::MODE_POSITION_REL));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
    end else if (clk_en) begin
      if (aw_take) begin
        aw_addr <= s_axi_awaddr;
      end
      if (w_take) begin
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      aw_held <= aw_now && !wr_fire;
      w_held <= w_now && !wr_fire;
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_map ? 2'b00 : 2'b10;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // configuration registers
  // ------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      axis_input_enable <= axis_monitor_pkg::RESET_INPUT_ENABLE;
      axis_input_polarity <= axis_monitor_pkg::RESET_INPUT_POLARITY;
      overrun_report_select <= axis_monitor_pkg::RESET_OVERRUN_REPORT;
    end else if (clk_en) begin
      if (wr_enable) begin
        axis_input_enable <= wr_data[3:0];
      end
      if (wr_polarity) begin
        axis_input_polarity <= wr_data[3:0];
      end
      if (wr_report) begin
        overrun_report_select <= wr_data[0];
      end
    end
  end

  // ------------------------------------------------------------
  // event latch: set wins over fault reset clear
  // ------------------------------------------------------------
  wire [3:0] event_set = {input_active[axis_monitor_pkg::BIT_REF],
    input_active[axis_monitor_pkg::BIT_STOP],
    input_active[axis_monitor_pkg::BIT_NEG_LIMIT],
    input_active[axis_monitor_pkg::BIT_POS_LIMIT]};
  wire [3:0] next_event_latch = (cmd_fault_reset ? 4'h0 : axis_event_latch) | event_set;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      axis_event_latch <= 4'h0;
    end else if (clk_en) begin
      axis_event_latch <= next_event_latch;
    end
  end

  // ------------------------------------------------------------
  // drive state: quick stop and its release paths
  // ------------------------------------------------------------
  // any stop cause also drops the running mode back to idle
  wire stop_cause = cmd_sw_stop || limit_hit || stop_hit;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= axis_monitor_pkg::ST_OPERATION_ENABLED;
    end else if (clk_en) begin
      unique case (state)
        axis_monitor_pkg::ST_OPERATION_ENABLED: begin
          if (cmd_sw_stop) begin
            state <= axis_monitor_pkg::ST_QUICK_STOP;
          end else if (limit_hit || stop_hit) begin
            state <= axis_monitor_pkg::ST_FAULT;
          end
        end
        axis_monitor_pkg::ST_QUICK_STOP: begin
          if (limit_hit || stop_hit) begin
            state <= axis_monitor_pkg::ST_FAULT;
          end else if (cmd_fault_reset || cmd_qs_release) begin
            state <= axis_monitor_pkg::ST_OPERATION_ENABLED;
          end
        end
        axis_monitor_pkg::ST_FAULT: begin
          // stop input must already be released before the reset takes
          if (cmd_fault_reset && !stop_hit) begin
            state <= axis_monitor_pkg::ST_OPERATION_ENABLED;
          end
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // motion mode and position counter
  // ------------------------------------------------------------
  // default width gives the full signed range; a narrower counter only shortens the wrap
  localparam logic signed [POS_WIDTH-1:0] POS_MAX = {1'b0, {(POS_WIDTH - 1){1'b1}}};
  localparam logic signed [POS_WIDTH-1:0] POS_MIN = {1'b1, {(POS_WIDTH - 1){1'b0}}};
  wire signed [POS_WIDTH-1:0] step_inc = POS_WIDTH'(pos_step_up);
  wire signed [POS_WIDTH-1:0] step_dec = POS_WIDTH'(pos_step_down);
  wire signed [POS_WIDTH-1:0] next_position = position + step_inc - step_dec;
  // natural wrap of the counter is the range shift by its full span
  wire wrap_up = pos_step_up && !pos_step_down && (position == POS_MAX);
  wire wrap_down = pos_step_down && !pos_step_up && (position == POS_MIN);
  wire wrap = wrap_up || wrap_down;
  // other modes stop at the limit instead of wrapping
  wire step_blocked = wrap && !wrap_ok;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode <= axis_monitor_pkg::MODE_IDLE;
      position <= '0;
      overrun_warning <= 1'b0;
      ref_ok <= 1'b0;
    end else if (clk_en) begin
      if (stop_cause || state != axis_monitor_pkg::ST_OPERATION_ENABLED) begin
        mode <= axis_monitor_pkg::MODE_IDLE;
      end else if (req_ok) begin
        mode <= axis_monitor_pkg::motion_mode_e'(req_mode);
      end
      if (!step_blocked) begin
        position <= next_position;
      end
      if (homing || dim_set) begin
        position <= '0;
        overrun_warning <= 1'b0;
        ref_ok <= 1'b1;
      end
      if (wrap && wrap_ok) begin
        overrun_warning <= 1'b1;
        ref_ok <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // AXI4-Lite read path
  // ------------------------------------------------------------
  wire [31:0] drive_status_word = {24'h0,
    overrun_report_select && overrun_warning,
    3'b000,
    req_abs_blocked(overrun_warning),
    amp_enable,
    state == axis_monitor_pkg::ST_OPERATION_ENABLED,
    state == axis_monitor_pkg::ST_QUICK_STOP};

  function automatic logic req_abs_blocked(input logic ov);
    req_abs_blocked = ov;
  endfunction

  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0;
    unique case (s_axi_araddr)
      axis_monitor_pkg::ADDR_AXIS_INPUT_ENABLE: rd_mux = {28'h0, axis_input_enable};
      axis_monitor_pkg::ADDR_AXIS_INPUT_POLARITY: rd_mux = {28'h0, axis_input_polarity};
      axis_monitor_pkg::ADDR_AXIS_EVENT_LATCH: rd_mux = {28'h0, axis_event_latch};
      axis_monitor_pkg::ADDR_WARNING_WORD: rd_mux = {31'h0, overrun_warning};
      axis_monitor_pkg::ADDR_ACTUAL_MODE_STATUS: rd_mux = {26'h0, ref_ok, 2'b00, mode};
      axis_monitor_pkg::ADDR_OVERRUN_REPORT_SELECT: rd_mux = {31'h0, overrun_report_select};
      axis_monitor_pkg::ADDR_DRIVE_STATUS_WORD: rd_mux = drive_status_word;
      // narrow counters read back sign-extended
      axis_monitor_pkg::ADDR_POSITION: rd_mux = 32'(position);
      default: rd_mux = 32'h0;
    endcase
  end

  wire rd_map = (s_axi_araddr <= axis_monitor_pkg::ADDR_MOTION_REQUEST)
    && (s_axi_araddr[1:0] == 2'b00);
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= 2'b00;
    end else if (clk_en) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_mux;
        s_axi_rresp <= rd_map ? 2'b00 : 2'b10;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // drive outputs
  // ------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      quick_stop <= 1'b0;
      amp_enable <= 1'b0;
      motion_active <= 1'b0;
    end else if (clk_en) begin
      quick_stop <= stop_cause || (state != axis_monitor_pkg::ST_OPERATION_ENABLED);
      // amplifier drops only on a switch fault; software stop keeps it on
      amp_enable <= (state != axis_monitor_pkg::ST_FAULT);
      motion_active <= (mode != axis_monitor_pkg::MODE_IDLE);
    end
  end

endmodule

// file: testbench/axis_monitor_checker.sv
/*
  Checker for axis_monitor: bus handshake and stop response properties.
  Assumes the master offers write address and data in the same cycle.
*/
`timescale 1ns/1ps

module axis_monitor_checker (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic stop_switch,
  input wire logic quick_stop,
  input wire logic amp_enable,
  input wire logic motion_active
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic wr_go;
  logic [3:0] en;
  logic [3:0] pol;
  assign wr_go = clk_en && s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  // ------------------------------
  // shadow settings
  // ------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      en <= 4'h0;
      pol <= 4'h0;
    end else if (wr_go && s_axi_awaddr == axis_monitor_pkg::ADDR_AXIS_INPUT_ENABLE) begin
      en <= s_axi_wdata[3:0];
    end else if (wr_go && s_axi_awaddr == axis_monitor_pkg::ADDR_AXIS_INPUT_POLARITY) begin
      pol <= s_axi_wdata[3:0];
    end
  end
  a_write_answer: assert property (wr_go |=> s_axi_bvalid)
    else $error("write response missing");
  a_read_answer: assert property (clk_en && s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response missing");
  a_write_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while response pending");
  a_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while data pending");
  a_bvalid_clears: assert property (s_axi_bvalid && s_axi_bready && clk_en |=> !s_axi_bvalid)
    else $error("write response not released");
  a_stop_switch_qs: assert property (
    (clk_en && en[2] && stop_switch == pol[2]) [*6] |-> quick_stop)
    else $error("stop switch gave no quick stop");
  a_sw_stop_amp: assert property (
    wr_go && s_axi_awaddr == axis_monitor_pkg::ADDR_DRIVE_COMMAND_WORD && s_axi_wdata[2]
    |-> ##[1:3] (quick_stop && amp_enable))
    else $error("software stop did not stop with amplifier on");
  a_stop_idles: assert property ($rose(quick_stop) |-> ##[0:2] !motion_active)
    else $error("motion still active after stop");
  a_reset_amp: assert property ($rose(aresetn) && clk_en |=> amp_enable)
    else $error("amplifier off after reset release");
endmodule

bind axis_monitor axis_monitor_checker u_checker (
  .aclk, .aresetn, .clk_en, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wdata, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .stop_switch, .quick_stop,
  .amp_enable, .motion_active
);

// file: testbench/axis_switch_model.sv
/*
  Far-side model: the four switch pins and the motion feedback pulses.
  Assumes callers start each task just after a rising clock edge.
*/
`timescale 1ns/1ps

module axis_switch_model (
  input wire logic aclk,
  output logic pos_limit_switch,
  output logic neg_limit_switch,
  output logic stop_switch,
  output logic ref_switch,
  output logic pos_step_up,
  output logic pos_step_down
);
  // idle high so low-active inputs read inactive
  initial begin
    {ref_switch, stop_switch, neg_limit_switch, pos_limit_switch} = 4'hF;
    pos_step_up = 1'b0;
    pos_step_down = 1'b0;
  end
  task automatic set_pins(input logic [3:0] v);
    @(posedge aclk);
    {ref_switch, stop_switch, neg_limit_switch, pos_limit_switch} <= v;
  endtask
  // gap sets motor speed: one pulse then gap+1 idle cycles
  task automatic step(input int n, input logic up, input int gap);
    repeat (n) begin
      @(posedge aclk);
      pos_step_up <= up;
      pos_step_down <= !up;
      @(posedge aclk);
      pos_step_up <= 1'b0;
      pos_step_down <= 1'b0;
      repeat (gap) @(posedge aclk);
    end
  endtask
endmodule

// file: testbench/axis_monitor_test.sv
/*
  Self-checking bench for axis_monitor, driven as an AXI4-Lite master.
  Assumes axis_switch_model drives the switch pins and position pulses.
*/
`timescale 1ns/1ps

module axis_monitor_test;
  localparam logic [7:0] EN = axis_monitor_pkg::ADDR_AXIS_INPUT_ENABLE;
  localparam logic [7:0] POL = axis_monitor_pkg::ADDR_AXIS_INPUT_POLARITY;
  localparam logic [7:0] LAT = axis_monitor_pkg::ADDR_AXIS_EVENT_LATCH;
  localparam logic [7:0] CMD = axis_monitor_pkg::ADDR_DRIVE_COMMAND_WORD;
  localparam logic [7:0] WRN = axis_monitor_pkg::ADDR_WARNING_WORD;
  localparam logic [7:0] MOD = axis_monitor_pkg::ADDR_ACTUAL_MODE_STATUS;
  localparam logic [7:0] SEL = axis_monitor_pkg::ADDR_OVERRUN_REPORT_SELECT;
  localparam logic [7:0] STA = axis_monitor_pkg::ADDR_DRIVE_STATUS_WORD;
  localparam logic [7:0] POS = axis_monitor_pkg::ADDR_POSITION;
  localparam logic [7:0] REQ = axis_monitor_pkg::ADDR_MOTION_REQUEST;
  localparam logic [31:0] ALL = 32'hFFFFFFFF;
  logic aclk, aresetn, clk_en;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic pos_lim, neg_lim, stop_sw, ref_sw, step_up, step_down;
  logic quick_stop, amp_enable, motion_active;
  int fails = 0;
  int comparisons = 0;
  int cycles = 0;

  // narrow position counter so the range wrap is reachable in a short run
  axis_monitor #(.POS_WIDTH(8)) DUT (.aclk(aclk), .aresetn(aresetn), .clk_en(clk_en),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .pos_limit_switch(pos_lim), .neg_limit_switch(neg_lim), .stop_switch(stop_sw),
    .ref_switch(ref_sw), .pos_step_up(step_up), .pos_step_down(step_down),
    .quick_stop(quick_stop), .amp_enable(amp_enable), .motion_active(motion_active));
  axis_switch_model sw (.aclk(aclk), .pos_limit_switch(pos_lim), .neg_limit_switch(neg_lim),
    .stop_switch(stop_sw), .ref_switch(ref_sw), .pos_step_up(step_up),
    .pos_step_down(step_down));

  // ------------------------------
  // bus tasks
  // ------------------------------
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do @(negedge aclk); while ((awready && wready) !== 1'b1);
    @(posedge aclk);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    do @(negedge aclk); while (bvalid !== 1'b1);
    check("write resp", {30'h0, er}, {30'h0, bresp});
    @(posedge aclk);
    bready <= 1'b0;
  endtask
  // m masks bits whose value the test does not fix
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                        input logic [1:0] er, input string n);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(negedge aclk); while (arready !== 1'b1);
    @(posedge aclk);
    arvalid <= 1'b0;
    do @(negedge aclk); while (rvalid !== 1'b1);
    check(n, e, rdata & m);
    check(n, {30'h0, er}, {30'h0, rresp});
    @(posedge aclk);
    rready <= 1'b0;
  endtask
  task automatic test_done();
    if (fails == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  // whole sequence needs well under a thousand cycles
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      test_done();
    end
  end

  // ------------------------------
  // sequence
  // ------------------------------
  initial begin
    {aresetn, awaddr, araddr, wdata, awvalid, wvalid, bready, arvalid, rready} = '0;
    clk_en = 1'b1;
    wstrb = 4'hF;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    rd_chk(EN, ALL, 32'h0, 2'b00, "enable");
    rd_chk(POL, ALL, 32'h0, 2'b00, "polarity");
    rd_chk(LAT, ALL, 32'h0, 2'b00, "latch");
    rd_chk(STA, ALL, 32'h6, 2'b00, "status");
    rd_chk(8'h28, ALL, 32'h0, 2'b10, "unmapped");
    rd_chk(8'h02, ALL, 32'h0, 2'b10, "misaligned");
    wr(8'h28, 32'h1, 2'b10);
    wr(SEL, 32'h1, 2'b00);
    rd_chk(SEL, ALL, 32'h1, 2'b00, "report select");
    // stop switch, low active
    wr(EN, 32'h4, 2'b00);
    sw.set_pins(4'hB);
    repeat (6) @(posedge aclk);
    check("stop qs", 32'h1, quick_stop);
    check("amp off", 32'h0, amp_enable);
    sw.set_pins(4'hF);
    rd_chk(LAT, ALL, 32'h4, 2'b00, "stop latch");
    wr(CMD, 32'h8, 2'b00);
    rd_chk(LAT, ALL, 32'h0, 2'b00, "latch cleared");
    rd_chk(STA, 32'h7, 32'h6, 2'b00, "fault left");
    // limits: disabled, then high active
    sw.set_pins(4'hE);
    repeat (6) @(posedge aclk);
    rd_chk(LAT, ALL, 32'h0, 2'b00, "disabled limit");
    wr(POL, 32'h3, 2'b00);
    wr(EN, 32'h3, 2'b00);
    repeat (6) @(posedge aclk);
    rd_chk(LAT, ALL, 32'h2, 2'b00, "neg limit");
    sw.set_pins(4'hD);
    repeat (6) @(posedge aclk);
    rd_chk(LAT, ALL, 32'h3, 2'b00, "both limits");
    sw.set_pins(4'hC);
    repeat (6) @(posedge aclk);
    wr(CMD, 32'h8, 2'b00);
    rd_chk(LAT, ALL, 32'h0, 2'b00, "limits cleared");
    // jog, position count, software stop
    wr(REQ, 32'h11, 2'b00);
    sw.set_pins(4'hD);
    repeat (6) @(posedge aclk);
    check("jog retract", 32'h0, quick_stop);
    sw.set_pins(4'hC);
    rd_chk(MOD, 32'h7, 32'h1, 2'b00, "jog mode");
    check("moving", 32'h1, motion_active);
    sw.step(12, 1'b1, 0);
    rd_chk(POS, ALL, 32'd12, 2'b00, "one turn");
    sw.step(13, 1'b0, 2);
    rd_chk(POS, ALL, ALL, 2'b00, "signed pos");
    clk_en <= 1'b0;
    sw.step(3, 1'b1, 0);
    clk_en <= 1'b1;
    rd_chk(POS, ALL, ALL, 2'b00, "frozen pos");
    wr(CMD, 32'h4, 2'b00);
    repeat (2) @(posedge aclk);
    check("sw stop qs", 32'h1, quick_stop);
    check("amp kept", 32'h1, amp_enable);
    check("stopped", 32'h0, motion_active);
    rd_chk(STA, 32'h7, 32'h5, 2'b00, "qs state");
    rd_chk(MOD, 32'h7, 32'h0, 2'b00, "mode idle");
    wr(CMD, 32'h10, 2'b00);
    rd_chk(STA, 32'h7, 32'h6, 2'b00, "released");
    wr(CMD, 32'h4, 2'b00);
    wr(CMD, 32'h8, 2'b00);
    rd_chk(STA, 32'h7, 32'h6, 2'b00, "reset release");
    // homing without reference enable, then absolute move
    wr(REQ, 32'h12, 2'b00);
    rd_chk(MOD, 32'h20, 32'h20, 2'b00, "homed");
    rd_chk(POS, ALL, 32'h0, 2'b00, "home pos");
    wr(REQ, 32'h15, 2'b00);
    rd_chk(STA, 32'h8, 32'h0, 2'b00, "abs allowed");
    // 8-bit counter: ends are 32'h7F and, sign-extended, 32'hFFFFFF80
    sw.step(130, 1'b1, 0);
    rd_chk(POS, ALL, 32'h7F, 2'b00, "abs stops at limit");
    rd_chk(WRN, ALL, 32'h0, 2'b00, "no overrun");
    wr(REQ, 32'h14, 2'b00);
    sw.step(1, 1'b1, 0);
    rd_chk(POS, ALL, 32'hFFFFFF80, 2'b00, "wrapped");
    rd_chk(WRN, ALL, 32'h1, 2'b00, "overrun");
    rd_chk(MOD, 32'h27, 32'h4, 2'b00, "ref lost");
    rd_chk(STA, 32'h88, 32'h88, 2'b00, "overrun status");
    wr(REQ, 32'h15, 2'b00);
    rd_chk(MOD, 32'h7, 32'h4, 2'b00, "abs refused");
    wr(REQ, 32'h16, 2'b00);
    sw.step(1, 1'b1, 0);
    rd_chk(POS, ALL, 32'hFFFFFF81, 2'b00, "back in range");
    rd_chk(WRN, ALL, 32'h1, 2'b00, "overrun kept");
    wr(SEL, 32'h0, 2'b00);
    rd_chk(STA, 32'h80, 32'h0, 2'b00, "overrun unreported");
    wr(REQ, 32'h13, 2'b00);
    rd_chk(WRN, ALL, 32'h0, 2'b00, "overrun cleared");
    rd_chk(MOD, 32'h27, 32'h23, 2'b00, "dimension set");
    test_done();
  end
endmodule
